// ### hdl/adc_mode_pkg.sv
/*
  constants shared by the converter mode control: instruction codes, timing counts,
  output word lengths and status bit positions.
  assumes: instruction bit i holds the i-th serial bit received (first bit in bit 0).
*/
package adc_mode_pkg;
  // instruction codes, bit 0 is the first bit shifted in
  localparam logic [7:0] INS_POWER_UP   = 8'h50;
  localparam logic [7:0] INS_POWER_DOWN = 8'hd0;
  localparam logic [7:0] INS_READ_STAT  = 8'h30;
  localparam logic [7:0] INS_FMT_SIGN   = 8'hb0;
  localparam logic [7:0] INS_FMT_MASK   = 8'hfe;
  localparam logic [7:0] INS_ACQ        = 8'h70;
  localparam logic [7:0] INS_ACQ_MASK   = 8'hfc;
  localparam logic [7:0] INS_USER_MODE  = 8'hf0;
  localparam logic [7:0] INS_TEST_MODE  = 8'hf1;
  localparam logic [7:0] INS_TEST_MASK  = 8'hf1;
  localparam int         INS_CONV_BIT   = 4;
  // conversion instruction fields
  localparam int         FLD_SINGLE     = 0;
  localparam int         FLD_CH_LO      = 1;
  localparam int         FLD_POL_SWAP   = 5;
  localparam int         FLD_LEN16      = 6;
  localparam int         FLD_MSB_FIRST  = 7;
  // acquisition lengths in conversion-clock periods
  localparam logic [5:0] ACQ_6          = 6'h06;
  localparam logic [5:0] ACQ_10         = 6'h0a;
  localparam logic [5:0] ACQ_18         = 6'h12;
  localparam logic [5:0] ACQ_34         = 6'h22;
  localparam logic [1:0] ACQ_SEL_RESET  = 2'h1;
  localparam logic [5:0] CONV_PERIODS   = 6'h0d;
  // output word lengths
  localparam logic [4:0] LEN_12         = 5'h0c;
  localparam logic [4:0] LEN_16         = 5'h10;
  localparam logic [4:0] LEN_STATUS     = 5'h09;
  localparam logic [3:0] INS_BITS       = 4'h8;
  // status bit positions
  localparam int         ST_PU          = 0;
  localparam int         ST_PD          = 1;
  localparam int         ST_12          = 4;
  localparam int         ST_16          = 5;
  localparam int         ST_SIGN        = 6;
  localparam int         ST_MSB         = 7;
  localparam int         ST_TEST        = 8;
  // result code limits
  localparam logic [16:0] CODE_POS_MAX  = 17'h00fff;
  localparam logic [16:0] CODE_NEG_MAX  = 17'h01000;
  localparam int          CODE_SCALE_SH = 13;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          CODE_W        = 13;
endpackage

// ### hdl/pin_sync.sv
/*
  two-flop synchroniser with edge detection for a group of pins.
  assumes: inputs are asynchronous to clk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta  <= '0;
      level <= '0;
      last  <= '0;
    end else begin
      meta  <= pin;
      level <= meta;
      last  <= level;
    end
  end

  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule

// ### hdl/result_fifo.sv
/*
  small flip-flop fifo for conversion results, valid/ready on both sides.
  assumes: single clock; push and pop may happen in the same cycle.
*/
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ### hdl/adc_mode_control.sv
/*
  serial converter control: instruction shift-in, power arbitration, test mode,
  multiplexer routing, acquisition/conversion sequencing and result shift-out.
  assumes: all pins, including the conversion clock, are asynchronous to CLK and run
  well below CLK/4; analog difference and span are quasi-static over an acquisition.
*/
`timescale 1ns/1ps
module adc_mode_control
  import adc_mode_pkg::*;
(
  input  wire logic                     CLK,
  input  wire logic                     RST,
  input  wire logic                     CS_N,
  input  wire logic                     SCLK,
  input  wire logic                     SERIAL_INSTRUCTION_IN,
  input  wire logic                     CONV_N,
  input  wire logic                     POWER_DOWN_PIN,
  input  wire logic                     CONVERSION_CLOCK,
  input  wire logic signed [15:0]       VIN_DIFF,
  input  wire logic [15:0]              VREF_SPAN,
  output logic                          SERIAL_DATA_OUT,
  output logic                          EOC,
  output logic                          POWERED_DOWN,
  output logic                          CONVERTER_ACTIVE,
  output logic                          SAMPLE_HOLD,
  output logic                          RESULT_VALID,
  output logic                          TEST_MODE,
  output logic [7:0]                    ANALOG_CHANNEL_PINS_OUT,
  output logic [7:0]                    ANALOG_CHANNEL_PINS_OE,
  output logic [2:0]                    MUX_OUTPUT_A_SEL,
  output logic [2:0]                    MUX_OUTPUT_B_SEL,
  output logic                          MUX_OUTPUT_B_COMMON,
  output logic                          CONVERTER_INPUT_A_POSITIVE
);
  import adc_mode_pkg::*;

  typedef enum logic [1:0] {IDLE, ACQUIRE, CONVERT, DONE} conv_state_t;

  logic [5:0] lvl;
  logic [5:0] rise;
  logic [5:0] fall;
  logic       cs_n;
  logic       din;
  logic       conv_n;
  logic       pd_pin;
  logic       cs_fall;
  logic       cs_rise;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       conversion_clock_rise;
  logic       pd_fall;

  pin_sync #(.WIDTH(6)) u_sync (
    .clk   (CLK),
    .rst   (RST),
    // select enters inverted so the reset value of the flops equals its idle level
    .pin   ({CONVERSION_CLOCK, POWER_DOWN_PIN, CONV_N, SERIAL_INSTRUCTION_IN, SCLK, ~CS_N}),
    .level (lvl),
    .rise  (rise),
    .fall  (fall)
  );

  assign cs_n      = !lvl[0];
  assign din       = lvl[2];
  assign conv_n    = lvl[3];
  assign pd_pin    = lvl[4];
  assign cs_fall   = rise[0];
  assign cs_rise   = fall[0];
  assign sclk_rise = rise[1] && !cs_n;
  assign sclk_fall = fall[1] && !cs_n;
  assign pd_fall   = fall[4];
  assign conversion_clock_rise = rise[5];

  // configuration and mode state
  logic        sw_pd;
  logic        test_mode;
  logic        sign_on;
  logic        len16;
  logic        msb_first;
  logic [1:0]  acq_sel;
  logic        single_ended;
  logic [2:0]  channel;
  logic        pol_swap;
  logic        status_pending;
  logic        result_invalid;
  logic        powered_down;

  // serial state
  logic [7:0]  instr;
  logic [4:0]  bit_cnt;
  logic        conv_seen;
  logic        frame_start;
  logic        cont_restart;
  logic [16:0] out_word;
  logic [4:0]  out_len;
  logic        out_msb;
  logic [4:0]  out_idx;
  logic [4:0]  word_len;
  logic        frame_end;
  logic        decode;
  logic        start_conv;
  logic [8:0]  status;
  logic [7:0]  next_instr;

  // converter state
  conv_state_t            state;
  logic [5:0]             cnt;
  logic [5:0]             acq_len;
  logic signed [15:0]     held_diff;
  logic [15:0]            held_span;
  logic [CODE_W-1:0]      code;
  logic [CODE_W-1:0]      last_code;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [CODE_W-1:0]      fifo_out_data;
  logic                   abort;
  logic [CODE_W-1:0]      fifo_sel;

  assign powered_down = pd_pin || sw_pd;
  assign word_len     = (len16 ? LEN_16 : LEN_12) + {4'h0, sign_on};
  // continuous chip select: frame closes on the expected clock count
  assign frame_end    = cs_rise || (sclk_rise && (bit_cnt == word_len - 5'h01));
  assign decode       = frame_end && (bit_cnt >= {1'b0, INS_BITS} - 5'h01 || cs_rise)
                        && (bit_cnt >= {1'b0, INS_BITS}
                            || (sclk_rise && bit_cnt == {1'b0, INS_BITS} - 5'h01))
                        && !conv_seen && !conv_n;
  assign start_conv   = decode && !next_instr[INS_CONV_BIT] && !powered_down;
  assign frame_start  = cs_fall || cont_restart;
  assign abort        = (state != IDLE && state != DONE) && (powered_down || cs_fall);

  // the instruction including a bit shifted in on the closing edge
  assign next_instr = (sclk_rise && bit_cnt < {1'b0, INS_BITS}) ? {din, instr[7:1]} : instr;

  assign status = {test_mode, msb_first, sign_on, len16, !len16, 1'b0, 1'b0,
                   powered_down, 1'b0};

  // serial instruction shift-in, runs regardless of power state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      instr        <= 8'h00;
      bit_cnt      <= 5'h00;
      conv_seen    <= 1'b0;
      cont_restart <= 1'b0;
    end else begin
      cont_restart <= frame_end && !cs_n && !cs_rise;
      if (frame_start) begin
        bit_cnt   <= 5'h00;
        conv_seen <= conv_n;
      end else if (frame_end) begin
        bit_cnt   <= 5'h00;
      end else if (sclk_rise) begin
        instr     <= next_instr;
        bit_cnt   <= bit_cnt + 5'h01;
        conv_seen <= conv_seen || conv_n;
      end
    end
  end

  // instruction decode into mode and configuration
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sw_pd          <= 1'b0;
      test_mode      <= 1'b0;
      sign_on        <= 1'b1;
      len16          <= 1'b0;
      msb_first      <= 1'b1;
      acq_sel        <= ACQ_SEL_RESET;
      single_ended   <= 1'b0;
      channel        <= 3'h0;
      pol_swap       <= 1'b0;
      status_pending <= 1'b0;
    end else begin
      if (pd_fall) begin
        sw_pd <= 1'b0;
      end
      if (frame_start) begin
        status_pending <= 1'b0;
      end
      if (decode) begin
        if (!next_instr[INS_CONV_BIT]) begin
          single_ended <= next_instr[FLD_SINGLE];
          channel      <= next_instr[FLD_CH_LO +: 3];
          pol_swap     <= next_instr[FLD_POL_SWAP];
          len16        <= next_instr[FLD_LEN16];
          msb_first    <= next_instr[FLD_MSB_FIRST];
        end else if (next_instr == INS_POWER_UP) begin
          sw_pd <= 1'b0;
        end else if (next_instr == INS_POWER_DOWN) begin
          sw_pd <= 1'b1;
        end else if (next_instr == INS_READ_STAT) begin
          status_pending <= 1'b1;
        end else if ((next_instr & INS_FMT_MASK) == INS_FMT_SIGN) begin
          sign_on <= next_instr[0];
        end else if ((next_instr & INS_ACQ_MASK) == INS_ACQ) begin
          acq_sel <= {next_instr[0], next_instr[1]};
        end else if (next_instr == INS_USER_MODE) begin
          test_mode <= 1'b0;
        end else if ((next_instr & INS_TEST_MASK) == INS_TEST_MODE) begin
          test_mode <= 1'b1;
        end
      end
    end
  end

  // serial shift-out: first bit at frame start, the rest on falling serial clock
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_word        <= 17'h00000;
      out_len         <= LEN_12 + 5'h01;
      out_msb         <= 1'b1;
      out_idx         <= 5'h00;
      last_code       <= '0;
      SERIAL_DATA_OUT <= 1'b0;
    end else begin
      if (frame_start) begin
        out_idx <= 5'h00;
        if (status_pending) begin
          out_word        <= {8'h00, status};
          out_len         <= LEN_STATUS;
          out_msb         <= 1'b0;
          SERIAL_DATA_OUT <= status[0];
        end else begin
          // a read-only frame repeats the last result when no new one is queued
          out_word  <= {{4{fifo_sel[CODE_W-1] & sign_on}}, fifo_sel};
          out_len   <= word_len;
          out_msb   <= msb_first;
          last_code <= fifo_sel;
          SERIAL_DATA_OUT <= msb_first ? fifo_sel[CODE_W-1] & sign_on : fifo_sel[0];
        end
      end else if (sclk_fall && out_idx < out_len - 5'h01) begin
        out_idx         <= out_idx + 5'h01;
        SERIAL_DATA_OUT <= out_word[out_msb ? out_len - out_idx - 5'h02 : out_idx + 5'h01];
      end
    end
  end

  assign fifo_sel = fifo_out_valid ? fifo_out_data : last_code;

  // acquisition length select
  always_comb begin
    case (acq_sel)
      2'h0:    acq_len = ACQ_6;
      2'h1:    acq_len = ACQ_10;
      2'h2:    acq_len = ACQ_18;
      2'h3:    acq_len = ACQ_34;
      default: acq_len = ACQ_10;
    endcase
  end

  // rounding and clamping of the held analog difference
  logic [15:0] mag;
  logic [30:0] num;
  logic [30:0] den;
  logic [30:0] quo;
  logic [16:0] clamped;
  always_comb begin
    mag     = held_diff[15] ? 16'(-held_diff) : 16'(held_diff);
    num     = {2'b00, mag, 13'h0000} + {15'h0000, held_span};
    den     = (held_span == 16'h0000) ? 31'h1 : {14'h0000, held_span, 1'b0};
    quo     = num / den;
    clamped = held_diff[15] ? ((quo > 31'(CODE_NEG_MAX)) ? CODE_NEG_MAX : quo[16:0])
                            : ((quo > 31'(CODE_POS_MAX)) ? CODE_POS_MAX : quo[16:0]);
    if (single_ended && held_diff[15]) begin
      code = '0;
    end else if (held_diff[15]) begin
      code = CODE_W'(17'h00000 - clamped);
    end else begin
      code = clamped[CODE_W-1:0];
    end
  end

  // acquisition and conversion sequencing on conversion-clock edges
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state          <= IDLE;
      cnt            <= 6'h00;
      held_diff      <= 16'h0000;
      held_span      <= 16'h0000;
      result_invalid <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          if (start_conv) begin
            state <= ACQUIRE;
            cnt   <= 6'h00;
          end
        end
        ACQUIRE: begin
          if (abort) begin
            state <= IDLE;
          end else if (conversion_clock_rise) begin
            // one rise more than the setting: never short, at most one period long
            if (cnt == acq_len) begin
              state     <= CONVERT;
              cnt       <= 6'h00;
              held_diff <= VIN_DIFF;
              held_span <= VREF_SPAN;
            end else begin
              cnt <= cnt + 6'h01;
            end
          end
        end
        CONVERT: begin
          if (abort) begin
            state <= IDLE;
          end else if (conversion_clock_rise) begin
            if (cnt == CONV_PERIODS - 6'h01) begin
              state <= DONE;
            end else begin
              cnt <= cnt + 6'h01;
            end
          end
        end
        DONE: begin
          // a full queue holds the converter here until a frame drains it
          if (fifo_in_ready) begin
            state          <= IDLE;
            result_invalid <= 1'b0;
          end
        end
        default: state <= IDLE;
      endcase
      if (abort && powered_down) begin
        result_invalid <= 1'b1;
      end
    end
  end

  result_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (state == DONE),
    .in_ready  (fifo_in_ready),
    .in_data   (code),
    .out_valid (fifo_out_valid),
    .out_ready (frame_start && !status_pending),
    .out_data  (fifo_out_data)
  );

  // registered outputs and multiplexer routing
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      EOC                        <= 1'b1;
      POWERED_DOWN               <= 1'b0;
      CONVERTER_ACTIVE           <= 1'b1;
      SAMPLE_HOLD                <= 1'b0;
      RESULT_VALID               <= 1'b1;
      TEST_MODE                  <= 1'b0;
      ANALOG_CHANNEL_PINS_OUT    <= 8'h00;
      ANALOG_CHANNEL_PINS_OE     <= 8'h00;
      MUX_OUTPUT_A_SEL           <= 3'h0;
      MUX_OUTPUT_B_SEL           <= 3'h1;
      MUX_OUTPUT_B_COMMON        <= 1'b0;
      CONVERTER_INPUT_A_POSITIVE <= 1'b1;
    end else begin
      EOC                     <= state == IDLE;
      POWERED_DOWN            <= powered_down;
      CONVERTER_ACTIVE        <= !powered_down;
      SAMPLE_HOLD             <= state == ACQUIRE;
      RESULT_VALID            <= !result_invalid;
      TEST_MODE               <= test_mode;
      ANALOG_CHANNEL_PINS_OUT <= 8'h00;
      ANALOG_CHANNEL_PINS_OE  <= {8{test_mode}};
      if (single_ended) begin
        MUX_OUTPUT_A_SEL           <= channel;
        MUX_OUTPUT_B_SEL           <= 3'h0;
        MUX_OUTPUT_B_COMMON        <= 1'b1;
        CONVERTER_INPUT_A_POSITIVE <= 1'b1;
      end else begin
        MUX_OUTPUT_A_SEL           <= {channel[2:1], 1'b0};
        MUX_OUTPUT_B_SEL           <= {channel[2:1], 1'b1};
        MUX_OUTPUT_B_COMMON        <= 1'b0;
        CONVERTER_INPUT_A_POSITIVE <= !pol_swap;
      end
    end
  end
endmodule

// ### tb/adc_mode_control_sva.sv
/*
  port checker for the converter mode control.
  assumes: one clock domain, reset active high.
*/
`timescale 1ns/1ps
module adc_mode_checker (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       CONV_N,
  input wire logic       POWER_DOWN_PIN,
  input wire logic       EOC,
  input wire logic       POWERED_DOWN,
  input wire logic       CONVERTER_ACTIVE,
  input wire logic       SAMPLE_HOLD,
  input wire logic       TEST_MODE,
  input wire logic [7:0] ANALOG_CHANNEL_PINS_OE,
  input wire logic [2:0] MUX_OUTPUT_A_SEL,
  input wire logic [2:0] MUX_OUTPUT_B_SEL,
  input wire logic       MUX_OUTPUT_B_COMMON,
  input wire logic       CONVERTER_INPUT_A_POSITIVE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // pin passes two flops and an output register
  a_pin_down: assert property (POWER_DOWN_PIN [*5] |-> POWERED_DOWN)
    else $error("pin high but converter up");
  a_active_inv: assert property (CONVERTER_ACTIVE != POWERED_DOWN)
    else $error("active flag not inverse of power-down");
  a_down_no_acq: assert property (POWERED_DOWN [*3] |-> !SAMPLE_HOLD)
    else $error("acquisition while powered down");
  a_test_drive: assert property (TEST_MODE [*2] |-> ANALOG_CHANNEL_PINS_OE == 8'hff)
    else $error("channel pins not driven in test mode");
  a_user_float: assert property (!TEST_MODE [*2] |-> ANALOG_CHANNEL_PINS_OE == 8'h00)
    else $error("channel pins driven in user mode");
  a_diff_pair: assert property (!MUX_OUTPUT_B_COMMON [*2] |-> !MUX_OUTPUT_A_SEL[0] &&
    MUX_OUTPUT_B_SEL == MUX_OUTPUT_A_SEL + 3'h1) else $error("bad differential pair");
  a_single_pos: assert property (MUX_OUTPUT_B_COMMON [*2] |-> CONVERTER_INPUT_A_POSITIVE)
    else $error("single-ended input a not positive");
  a_hold_busy: assert property (SAMPLE_HOLD |-> !EOC)
    else $error("end of conversion during acquisition");
  // convert pin seen high at frame end must block the start
  a_read_only: assert property ($fell(EOC) |-> !$past(CONV_N, 4))
    else $error("conversion started from read-only frame");
  a_cs_abort: assert property ($fell(CS_N) && SAMPLE_HOLD |-> ##[1:12] EOC)
    else $error("chip select did not end conversion");
endmodule

bind adc_mode_control adc_mode_checker chk (.CLK, .RST, .CS_N, .CONV_N, .POWER_DOWN_PIN,
  .EOC, .POWERED_DOWN, .CONVERTER_ACTIVE, .SAMPLE_HOLD, .TEST_MODE, .ANALOG_CHANNEL_PINS_OE,
  .MUX_OUTPUT_A_SEL, .MUX_OUTPUT_B_SEL, .MUX_OUTPUT_B_COMMON, .CONVERTER_INPUT_A_POSITIVE);

// ### tb/host_model.sv
/*
  host controller model: frames instructions and reads serial data.
  assumes: bench clock given; pins change at falling clock edges.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,
  input  wire logic dout,
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  output logic      conv_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    conv_n = 1'b0;
  end
  // serial clock idles low between frames; 64 ns period
  task automatic frame(input logic [7:0] ins, input int n, input logic ro,
                       output logic [16:0] w);
    w = '0;
    @(negedge clk);
    conv_n = ro;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = (i < 8) ? ins[i] : ~din;
      repeat (8) @(negedge clk);
      w = {w[15:0], dout};
      sclk = 1'b1;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    din = ~din;
    // convert pin held past decode so the frame stays read-only
    repeat (16) @(negedge clk);
    conv_n = 1'b0;
  endtask
endmodule

// ### tb/tb_top.sv
/*
  bench for the converter mode control, host model on the serial side.
  assumes: design, package and host model compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import adc_mode_pkg::*;
  logic               clk, rst, cs_n, sclk, din, conv_n, pd_pin, conversion_clock;
  logic signed [15:0] vin;
  logic        [15:0] vref;
  logic               dout, eoc, pdn, act, sh, rvalid, tmode, bcom, apos;
  logic        [7:0]  ch_out, ch_oe;
  logic        [2:0]  mux_a, mux_b;
  logic        [16:0] w;
  int                 bad_count, num_checks, acq_cnt;
  int                 acq_len[4] = '{6, 10, 18, 34};
  int                 cv[6] = '{1000, -5000, 5000, -1, 3, -3};
  int                 cr[6] = '{4096, 4096, 4096, 4096, 8192, 8192};
  logic        [12:0] ce[6] = '{13'h03e8, 13'h1000, 13'h0fff, 13'h1fff, 13'h0002, 13'h1ffe};
  logic        [7:0]  leave[7] = '{8'h70, 8'h50, 8'hd0, 8'hf0, 8'h50, 8'hb0, 8'h72};

  initial clk = 1'b0;
  always #2 clk = ~clk;
  // odd-ns edges keep the conversion clock off the system clock edges
  initial begin
    conversion_clock = 1'b0;
    #1;
    forever #20 conversion_clock = ~conversion_clock;
  end
  always @(posedge conversion_clock) if (sh === 1'b1) acq_cnt++;

  adc_mode_control dut (.CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk),
    .SERIAL_INSTRUCTION_IN(din), .CONV_N(conv_n), .POWER_DOWN_PIN(pd_pin),
    .CONVERSION_CLOCK(conversion_clock), .VIN_DIFF(vin), .VREF_SPAN(vref), .SERIAL_DATA_OUT(dout),
    .EOC(eoc), .POWERED_DOWN(pdn), .CONVERTER_ACTIVE(act), .SAMPLE_HOLD(sh),
    .RESULT_VALID(rvalid), .TEST_MODE(tmode), .ANALOG_CHANNEL_PINS_OUT(ch_out),
    .ANALOG_CHANNEL_PINS_OE(ch_oe), .MUX_OUTPUT_A_SEL(mux_a), .MUX_OUTPUT_B_SEL(mux_b),
    .MUX_OUTPUT_B_COMMON(bcom), .CONVERTER_INPUT_A_POSITIVE(apos));
  host_model host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din),
    .conv_n(conv_n));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_flag(input bit acq);
    int i;
    i = 0;
    while (((acq ? sh : eoc) !== 1'b1) && i < 5000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 5000) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic send(input logic [7:0] ins);
    host.frame(ins, 8, 1'b0, w);
  endtask
  task automatic convert(input logic [7:0] ins);
    send(ins);
    wait_flag(1'b0);
  endtask
  task automatic pin(input logic v);
    pd_pin = v;
    repeat (8) @(negedge clk);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    pd_pin = 1'b0;
    vin = 16'sd1000;
    vref = 16'd4096;
    acq_cnt = 0;
    do_reset();
    check({pdn, act, tmode, eoc}, 4'b0101);
    send(INS_POWER_DOWN);
    check({pdn, act}, 2'b10);
    send(INS_READ_STAT);
    host.frame(INS_READ_STAT, 9, 1'b0, w);
    check(w[7], 1'b1);
    pin(1'b1);
    pin(1'b0);
    check(pdn, 1'b0);
    send(INS_POWER_DOWN);
    send(INS_POWER_UP);
    check(pdn, 1'b0);
    pin(1'b1);
    send(INS_POWER_UP);
    check(pdn, 1'b1);
    pin(1'b0);
    check(pdn, 1'b0);
    send(8'hf5);
    check({tmode, ch_oe, ch_out}, {1'b1, 8'hff, 8'h00});
    send(INS_READ_STAT);
    host.frame(INS_READ_STAT, 9, 1'b0, w);
    check(w[0], 1'b1);
    foreach (leave[i]) send(leave[i]);
    check({tmode, ch_oe, pdn}, 10'h000);
    send(8'hf1);
    do_reset();
    check({tmode, ch_oe}, 9'h000);
    vin = -16'sd100;
    for (int k = 0; k < 8; k++) begin
      convert({4'h8, k[2:0], 1'b1});
      check({mux_a, bcom, apos}, {k[2:0], 2'b11});
      if (k > 0) check(w[7], 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      convert({2'b10, k[0], 1'b0, k[1:0], 2'b00});
      check({mux_a, mux_b, bcom, apos}, {k[1:0], 1'b0, k[1:0], 2'b10, ~k[0]});
    end
    for (int k = 0; k < 6; k++) begin
      vin = 16'(cv[k]);
      vref = 16'(cr[k]);
      convert(8'h80);
      host.frame(8'h00, 13, 1'b1, w);
      check({w[12:0], eoc}, {ce[k], 1'b1});
    end
    for (int s = 0; s < 4; s++) begin
      send(INS_ACQ | {6'h00, s[0], s[1]});
      acq_cnt = 0;
      convert(8'h80);
      check(acq_cnt >= acq_len[s] && acq_cnt <= acq_len[s] + 1, 1'b1);
    end
    send(8'h80);
    wait_flag(1'b1);
    pin(1'b1);
    check({pdn, eoc, sh, rvalid}, 4'b1100);
    pin(1'b0);
    send(8'h80);
    wait_flag(1'b1);
    host.frame(8'h00, 8, 1'b1, w);
    check({eoc, sh}, 2'b10);
    end_sim();
  end
endmodule
